// ### common/slb_map.svh
// Register offsets, field positions, reset values and counts of the line binarizer
// Included by the binarizer top; holds definitions only
`ifndef SLB_MAP_SVH
`define SLB_MAP_SVH

`define SLB_CTRL_OFFSET       8'h00
`define SLB_STATUS_OFFSET     8'h04

`define SLB_CTRL_MODE_BIT     0
`define SLB_CTRL_DENS_LSB     1
`define SLB_CTRL_EDGE_BIT     3
`define SLB_CTRL_CAL_BIT      4
`define SLB_CTRL_START_BIT    5

`define SLB_MODE_RESET        1'b0
`define SLB_DENS_RESET        2'h1
`define SLB_EDGE_RESET        1'b0

`define SLB_LINE_PIXELS       12'ha20
`define SLB_LINE_LAST         12'ha1f
`define SLB_CENTER_FIRST      12'h410
`define SLB_CENTER_LAST       12'h60f
`define SLB_CAL_SCANS         3'h5
`define SLB_BLACK_REFERENCE   8'h00
`define SLB_PCT_FULL          18'h003e8
`define SLB_MTF_LEVEL_X2      8'sh10
`define SLB_EDGE_LEVEL        4'h6
`define SLB_DITHER_TABLE      64'h082ac4e63b19f7d5

// Breakpoints in tenths of a percent: upper, one, two, three, lower
`define SLB_PCT_LINE_LIGHTER  {10'h2e4, 10'h23a, 10'h190, 10'h0e6, 10'h03c}
`define SLB_PCT_LINE_NORMAL   {10'h3e8, 10'h2fd, 10'h212, 10'h127, 10'h03c}
`define SLB_PCT_LINE_DARKER1  {10'h3e8, 10'h31e, 10'h253, 10'h189, 10'h0be}
`define SLB_PCT_LINE_DARKER2  {10'h3e8, 10'h34d, 10'h2b2, 10'h217, 10'h17c}
`define SLB_PCT_PHOTO_LIGHTER {10'h2bc, 10'h16e, 10'h0c4, 10'h072, 10'h046}
`define SLB_PCT_PHOTO_NORMAL  {10'h320, 10'h1b2, 10'h0f8, 10'h09e, 10'h06e}
`define SLB_PCT_PHOTO_DARKER1 {10'h352, 10'h1df, 10'h122, 10'h0c7, 10'h096}
`define SLB_PCT_PHOTO_DARKER2 {10'h398, 10'h20b, 10'h140, 10'h0df, 10'h0aa}

`endif

// ### common/slb_mem_if.sv
// Port bundle between the binarizer and one of its line memories
// Assumes one writer and one reader on the same clock
`timescale 1ns/1ns
interface slb_mem_if #(parameter int WIDTH = 4, parameter int ADDR = 12);
  logic             wr_en;
  logic [ADDR-1:0]  wr_addr;
  logic [WIDTH-1:0] wr_data;
  logic             rd_en;
  logic [ADDR-1:0]  rd_addr;
  logic [WIDTH-1:0] rd_data;
  modport user  (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// ### common/slb_pkg.sv
// Types shared by the line binarizer modules
// Assumes nothing beyond a SystemVerilog compiler
package slb_pkg;
  typedef enum {SLB_IDLE, SLB_CALIB, SLB_ORIGINAL} slb_state_type;
  typedef enum logic [1:0] {SLB_LIGHTER, SLB_NORMAL, SLB_DARKER1, SLB_DARKER2} slb_density_type;
  typedef logic [3:0] slb_code_type;
endpackage

// ### core/slb_binarizer.sv
// Scan line binarizer: shading correction, white peak, 16-level quantizer, line/photo bits
// Assumes an AXI4-Lite master on MCLK and a sensor front end strobing one sample per pixel
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "slb_map.svh"
module slb_binarizer
  import slb_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output wire logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output wire logic        WREADY,
  output wire logic [1:0]  BRESP,
  output wire logic        BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output wire logic        ARREADY,
  output wire logic [31:0] RDATA,
  output wire logic [1:0]  RRESP,
  output wire logic        RVALID,
  input  wire logic        RREADY,
  input  wire logic [7:0]  AMPLIFIED_VIDEO,
  input  wire logic        PIXEL_STROBE,
  input  wire logic        LINE_START,
  output wire logic        PIXEL_VALID,
  output wire logic        PIXEL_BLACK,
  output wire logic        PIXEL_FIRST
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  logic            aw_held, w_held, bvalid, rvalid;
  logic [7:0]      aw_addr;
  logic [31:0]     w_data, rdata;
  logic [3:0]      w_strb;
  logic [1:0]      bresp, rresp;
  logic            photo_mode, edge_on, calibrated, cal_armed;
  slb_density_type density;
  slb_state_type   state;
  logic [2:0]      scan_cnt;
  logic [7:0]      vid_s1, vid_s2, peak, a_data, corr, sample;
  logic            stb_s1, stb_s2, stb_d, ls_s1, ls_s2, ls_d, in_line;
  logic [11:0]     col, a_col, b_col, c_col;
  logic            a_valid, b_valid, flush;
  slb_code_type    b_code, level, kcalc, mid_l, mid_c, up_c, down_c;
  slb_code_type    right, up_eff, th;
  logic [7:0]      bp [0:4];
  logic [7:0]      thr [0:15];
  logic [49:0]     pct_row;
  logic [12:0]     gain_mul;
  logic [1:0]      lines_seen, out_row;
  logic signed [7:0] e2x2, e1x2;
  logic            out_valid, out_black, out_first, out_en, ev;
  logic            mtf_black, dith_black, edge_hit;
  logic            do_write, ctrl_hit, cal_cmd, start_cmd, pix_evt, line_evt, take;
  logic            cal_last, cal_done, cal_track, cal_write;

  slb_mem_if shade_if ();
  slb_mem_if cur_if ();
  slb_mem_if prev_if ();

  slb_line_mem #(.WIDTH(4), .DEPTH(2592)) shade_mem (.clk(MCLK), .port(shade_if.store));
  slb_line_mem #(.WIDTH(4), .DEPTH(2592)) cur_mem   (.clk(MCLK), .port(cur_if.store));
  slb_line_mem #(.WIDTH(4), .DEPTH(2592)) prev_mem  (.clk(MCLK), .port(prev_if.store));

  function automatic logic [3:0] absdiff(input logic [3:0] x, input logic [3:0] y);
    absdiff = (x > y) ? x - y : y - x;
  endfunction

  // Register bus slave
  assign AWREADY  = !aw_held;
  assign WREADY   = !w_held;
  assign ARREADY  = !rvalid;
  assign BVALID   = bvalid;
  assign BRESP    = bresp;
  assign RVALID   = rvalid;
  assign RDATA    = rdata;
  assign RRESP    = rresp;
  assign do_write = aw_held && w_held && !bvalid;
  assign ctrl_hit = aw_addr == `SLB_CTRL_OFFSET;
  assign cal_cmd  = do_write && ctrl_hit && w_strb[0] && w_data[`SLB_CTRL_CAL_BIT];
  assign start_cmd = do_write && ctrl_hit && w_strb[0] && w_data[`SLB_CTRL_START_BIT];

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end
    else
    begin
      if (AWVALID && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= (ctrl_hit || aw_addr == `SLB_STATUS_OFFSET) ? 2'h0 : 2'h2;
    end
    else if (BREADY)
      bvalid <= 1'b0;
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end
    else if (ARVALID && !rvalid)
    begin
      rvalid <= 1'b1;
      rresp  <= 2'h0;
      if (ARADDR == `SLB_CTRL_OFFSET)
        rdata <= {28'h0000000, edge_on, density, photo_mode};
      else if (ARADDR == `SLB_STATUS_OFFSET)
        rdata <= {13'h0000, scan_cnt, peak, 5'h00, state == SLB_ORIGINAL, calibrated,
                  state == SLB_CALIB};
      else
      begin
        rdata <= 32'h0000_0000;
        rresp <= 2'h2;
      end
    end
    else if (RREADY)
      rvalid <= 1'b0;
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      photo_mode <= `SLB_MODE_RESET;
      density    <= slb_density_type'(`SLB_DENS_RESET);
      edge_on    <= `SLB_EDGE_RESET;
    end
    else if (do_write && ctrl_hit && w_strb[0])
    begin
      photo_mode <= w_data[`SLB_CTRL_MODE_BIT];
      density    <= slb_density_type'(w_data[`SLB_CTRL_DENS_LSB +: 2]);
      edge_on    <= w_data[`SLB_CTRL_EDGE_BIT];
    end
  end

  // Pin synchronisers and pixel framing
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      {vid_s1, vid_s2} <= 16'h0000;
      {stb_s1, stb_s2, stb_d, ls_s1, ls_s2, ls_d} <= 6'h00;
    end
    else
    begin
      vid_s1 <= AMPLIFIED_VIDEO;
      vid_s2 <= vid_s1;
      {stb_s1, stb_s2, stb_d} <= {PIXEL_STROBE, stb_s1, stb_s2};
      {ls_s1, ls_s2, ls_d} <= {LINE_START, ls_s1, ls_s2};
    end
  end

  assign pix_evt  = stb_s2 && !stb_d;
  assign line_evt = ls_s2 && !ls_d;
  assign take     = pix_evt && in_line && col < `SLB_LINE_PIXELS;

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      col     <= 12'h000;
      in_line <= 1'b0;
      a_valid <= 1'b0;
      a_col   <= 12'h000;
      a_data  <= 8'h00;
    end
    else
    begin
      a_valid <= take;
      if (line_evt)
      begin
        col     <= 12'h000;
        in_line <= 1'b1;
      end
      else if (take)
      begin
        col    <= col + 12'h001;
        a_col  <= col;
        a_data <= vid_s2;
      end
    end
  end

  // Calibration sequence
  assign cal_last  = state == SLB_CALIB && cal_armed && a_valid && a_col == `SLB_LINE_LAST;
  assign cal_done  = cal_last && scan_cnt == `SLB_CAL_SCANS - 3'h1;
  assign cal_track = state == SLB_CALIB && cal_armed && scan_cnt < `SLB_CAL_SCANS - 3'h1;
  assign cal_write = state == SLB_CALIB && cal_armed && scan_cnt == `SLB_CAL_SCANS - 3'h1;

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state      <= SLB_IDLE;
      scan_cnt   <= 3'h0;
      cal_armed  <= 1'b0;
      calibrated <= 1'b0;
    end
    else if (cal_cmd)
    begin
      state      <= SLB_CALIB;
      scan_cnt   <= 3'h0;
      cal_armed  <= 1'b0;
      calibrated <= 1'b0;
    end
    else if (start_cmd)
      state <= SLB_ORIGINAL;
    else
    begin
      if (state == SLB_CALIB && line_evt)
        cal_armed <= 1'b1;
      if (cal_last)
        scan_cnt <= scan_cnt + 3'h1;
      if (cal_done)
      begin
        state      <= SLB_IDLE;
        calibrated <= 1'b1;
      end
    end
  end

  // Shading gain: stored code k means a gain of (16 + k) / 16
  assign gain_mul = 13'(a_data) * 13'({1'b1, shade_if.rd_data});
  assign corr = !calibrated ? a_data : gain_mul[12] ? 8'hff : gain_mul[11:4];

  always_comb
  begin
    kcalc = 4'h0;
    for (int k = 0; k < 16; k++)
      if (13'(a_data) * 13'(16 + k) <= {1'b0, peak, 4'h0})
        kcalc = 4'(k);
  end

  assign shade_if.rd_en   = take;
  assign shade_if.rd_addr = col;
  assign shade_if.wr_en   = a_valid && cal_write;
  assign shade_if.wr_addr = a_col;
  assign shade_if.wr_data = kcalc;

  // White peak hold
  assign sample = cal_track ? a_data : corr;

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      peak <= 8'h00;
    else if (cal_cmd || start_cmd)
      peak <= 8'h00;
    else if (a_valid && sample > peak && (cal_track || (state == SLB_ORIGINAL &&
             a_col >= `SLB_CENTER_FIRST && a_col <= `SLB_CENTER_LAST)))
      peak <= sample;
  end

  // Breakpoints and sixteen sub-thresholds
  always_comb
  begin
    unique case ({photo_mode, density})
      {1'b0, SLB_LIGHTER}: pct_row = `SLB_PCT_LINE_LIGHTER;
      {1'b0, SLB_NORMAL}:  pct_row = `SLB_PCT_LINE_NORMAL;
      {1'b0, SLB_DARKER1}: pct_row = `SLB_PCT_LINE_DARKER1;
      {1'b0, SLB_DARKER2}: pct_row = `SLB_PCT_LINE_DARKER2;
      {1'b1, SLB_LIGHTER}: pct_row = `SLB_PCT_PHOTO_LIGHTER;
      {1'b1, SLB_NORMAL}:  pct_row = `SLB_PCT_PHOTO_NORMAL;
      {1'b1, SLB_DARKER1}: pct_row = `SLB_PCT_PHOTO_DARKER1;
      {1'b1, SLB_DARKER2}: pct_row = `SLB_PCT_PHOTO_DARKER2;
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      bp <= '{default: 8'h00};
    else
      for (int i = 0; i < 5; i++)
        bp[i] <= `SLB_BLACK_REFERENCE + 8'(({10'h000, peak - `SLB_BLACK_REFERENCE} *
                 {8'h00, pct_row[49 - 10 * i -: 10]}) / `SLB_PCT_FULL);
  end

  always_comb
  begin
    logic [9:0] step;
    step = 10'h000;
    for (int k = 0; k < 16; k++)
    begin
      step   = {2'b00, bp[3 - k / 4] - bp[4 - k / 4]} * 10'(k % 4);
      thr[k] = bp[4 - k / 4] + step[9:2];
    end
  end

  always_comb
  begin
    level = 4'h0;
    for (int k = 1; k < 16; k++)
      if (corr >= thr[k])
        level = level + 4'h1;
  end

  // Quantized code is density: white gives 0, black 15
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      b_valid <= 1'b0;
      b_col   <= 12'h000;
      b_code  <= 4'h0;
      flush   <= 1'b0;
    end
    else
    begin
      b_valid <= a_valid;
      flush   <= b_valid && b_col == `SLB_LINE_LAST;
      if (a_valid)
      begin
        b_col  <= a_col;
        b_code <= 4'hf - level;
      end
    end
  end

  // Line store: current line into cur, displaced line into prev
  assign cur_if.rd_en    = a_valid;
  assign cur_if.rd_addr  = a_col;
  assign cur_if.wr_en    = b_valid;
  assign cur_if.wr_addr  = b_col;
  assign cur_if.wr_data  = b_code;
  assign prev_if.rd_en   = a_valid;
  assign prev_if.rd_addr = a_col;
  assign prev_if.wr_en   = b_valid;
  assign prev_if.wr_addr = b_col;
  assign prev_if.wr_data = cur_if.rd_data;

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      {mid_l, mid_c, up_c, down_c} <= 16'h0000;
      c_col      <= 12'h000;
      lines_seen <= 2'h0;
      out_row    <= 2'h0;
    end
    else
    begin
      if (b_valid)
      begin
        mid_l  <= (b_col == 12'h000) ? cur_if.rd_data : mid_c;
        mid_c  <= cur_if.rd_data;
        up_c   <= prev_if.rd_data;
        down_c <= b_code;
        c_col  <= b_col;
      end
      if (start_cmd)
      begin
        lines_seen <= 2'h0;
        out_row    <= 2'h0;
      end
      else if (flush)
      begin
        if (lines_seen != 2'h2)
          lines_seen <= lines_seen + 2'h1;
        if (lines_seen != 2'h0)
          out_row <= out_row + 2'h1;
      end
    end
  end

  // Decide the centre column once its right neighbour is known
  assign ev     = (b_valid && b_col != 12'h000) || flush;
  assign out_en = state == SLB_ORIGINAL && lines_seen != 2'h0;
  assign right  = flush ? mid_c : cur_if.rd_data;
  assign up_eff = (lines_seen == 2'h2) ? up_c : mid_c;
  assign e2x2 = $signed({2'b00, mid_c, 2'b00}) - $signed({4'h0, mid_l} + {4'h0, right});
  assign e1x2 = $signed({2'b00, mid_c, 2'b00}) - $signed({4'h0, up_eff} + {4'h0, down_c});
  assign mtf_black  = e2x2 >= `SLB_MTF_LEVEL_X2 || e1x2 >= `SLB_MTF_LEVEL_X2;
  assign th         = 4'(`SLB_DITHER_TABLE >> {~{out_row, c_col[1:0]}, 2'b00});
  assign dith_black = mid_c > th;
  assign edge_hit   = edge_on && (absdiff(mid_c, mid_l) > `SLB_EDGE_LEVEL ||
                      absdiff(mid_c, right) > `SLB_EDGE_LEVEL ||
                      absdiff(mid_c, up_eff) > `SLB_EDGE_LEVEL ||
                      absdiff(mid_c, down_c) > `SLB_EDGE_LEVEL);

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      out_valid <= 1'b0;
      out_black <= 1'b0;
      out_first <= 1'b0;
    end
    else
    begin
      out_valid <= ev && out_en;
      out_first <= ev && out_en && c_col == 12'h000;
      if (ev && out_en)
        out_black <= photo_mode ? (edge_hit ? mtf_black : dith_black) : mtf_black;
    end
  end

  assign PIXEL_VALID = out_valid;
  assign PIXEL_BLACK = out_black;
  assign PIXEL_FIRST = out_first;

  AST_PEAK_CLEAR: assert property (start_cmd |=> peak == 8'h00)
    else $error("peak not cleared at original start");
  AST_PEAK_HOLD: assert property (!cal_cmd && !start_cmd |=> peak >= $past(peak))
    else $error("peak dropped without reset");
  AST_PEAK_CENTER: assert property (state == SLB_ORIGINAL && a_valid && !start_cmd &&
    (a_col < `SLB_CENTER_FIRST || a_col > `SLB_CENTER_LAST) |=> $stable(peak))
    else $error("peak moved outside centre band");
  AST_CAL_FIVE: assert property ($rose(calibrated) |-> scan_cnt == `SLB_CAL_SCANS
    && state == SLB_IDLE)
    else $error("calibration ended after wrong scan count");
  AST_GAIN_FIT: assert property (shade_if.wr_en |->
    13'(a_data) * 13'({1'b1, shade_if.wr_data}) <= {1'b0, peak, 4'h0} &&
    (shade_if.wr_data == 4'hf || 13'(a_data) * 13'({1'b1, shade_if.wr_data} + 5'h01)
    > {1'b0, peak, 4'h0}))
    else $error("shading gain not the largest fitting the peak");
  AST_QUANT_TOP: assert property (a_valid && corr >= thr[15] |=> b_code == 4'h0)
    else $error("whitest sample not coded 0");
  AST_QUANT_FLOOR: assert property (a_valid && corr < thr[1] |=> b_code == 4'hf)
    else $error("darkest sample not coded 15");
  AST_LINE_UPPER: assert property (!photo_mode && density == SLB_NORMAL &&
    $stable(peak) && $stable(density) && $stable(photo_mode) |-> bp[0] == peak)
    else $error("line normal upper bound not at peak");
  AST_MTF_BLACK: assert property (ev && out_en && !photo_mode && mtf_black
    |=> PIXEL_VALID && PIXEL_BLACK)
    else $error("line mode pixel not black");
  AST_MTF_WHITE: assert property (ev && out_en && !photo_mode &&
    e2x2 < `SLB_MTF_LEVEL_X2 && e1x2 < `SLB_MTF_LEVEL_X2 |=> !PIXEL_BLACK)
    else $error("line mode pixel not white");
  AST_DITHER: assert property (ev && out_en && photo_mode && !edge_hit
    |=> PIXEL_BLACK == $past(dith_black))
    else $error("dither decision wrong");
endmodule

// ### core/slb_line_mem.sv
// One line of small words: write port and registered read port
// Assumes the user keeps addresses below the depth
`timescale 1ns/1ns
module slb_line_mem #(parameter int WIDTH = 4, parameter int DEPTH = 2592)
(
  input wire logic clk,
  slb_mem_if.store port
);
  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge clk)
  begin
    if (port.wr_en)
      cells[port.wr_addr] <= port.wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (port.rd_en)
      port.rd_data <= cells[port.rd_addr];
  end
endmodule

// ### tb/slb_binarizer_bench.sv
// Self-checking bench of the scan line binarizer: registers, calibration, one original
// Assumes the sensor model drives the video pins and AXI4-Lite tasks own the register bus
`timescale 1ns/1ns
module slb_binarizer_bench;
  logic        MCLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        AWVALID = 1'b0;
  logic        WVALID = 1'b0;
  logic        BREADY = 1'b0;
  logic        ARVALID = 1'b0;
  logic        RREADY = 1'b0;
  logic [7:0]  AWADDR = 8'h00;
  logic [7:0]  ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0]  WSTRB = 4'hf;
  wire  [7:0]  AMPLIFIED_VIDEO;
  wire         PIXEL_STROBE;
  wire         LINE_START;
  wire  [1:0]  BRESP;
  wire  [1:0]  RRESP;
  wire  [31:0] RDATA;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID;
  wire         PIXEL_VALID, PIXEL_BLACK, PIXEL_FIRST;
  int          n_fail = 0;
  int          tests_run = 0;
  int          n_valid = 0;
  int          n_black = 0;
  int          n_first = 0;
  int          black_early = 0;
  logic [31:0] rd;
  logic [1:0]  rsp;

  always #25 MCLK = ~MCLK;

  slb_binarizer i_slb_binarizer (.MCLK, .ARST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .AMPLIFIED_VIDEO, .PIXEL_STROBE, .LINE_START, .PIXEL_VALID,
    .PIXEL_BLACK, .PIXEL_FIRST);

  slb_video_model i_slb_video_model (.mclk(MCLK), .video(AMPLIFIED_VIDEO),
    .strobe(PIXEL_STROBE), .line_start(LINE_START));

  // Output pixel tally; the first 2592 belong to the first buffered line
  always @(posedge MCLK)
  begin
    if (PIXEL_VALID === 1'b1)
    begin
      if (PIXEL_BLACK === 1'b1 && n_valid < 2592)
        black_early++;
      n_black += (PIXEL_BLACK === 1'b1);
      n_first += (PIXEL_FIRST === 1'b1);
      n_valid++;
    end
  end

  task finish_test;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL time %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge MCLK);
      if (AWVALID && AWREADY === 1'b1)
        AWVALID <= 1'b0;
      if (WVALID && WREADY === 1'b1)
        WVALID <= 1'b0;
    end
    while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(posedge MCLK);
      if (ARVALID && ARREADY === 1'b1)
        ARVALID <= 1'b0;
    end
    while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  // Reset values, an unmapped read and a write to the read-only status word
  task automatic t_regs;
    axi_read(8'h00, rd, rsp);
    chk(rd, 32'h2);
    axi_read(8'h08, rd, rsp);
    chk({rd[29:0], rsp}, 32'h2);
    axi_write(8'h08, 32'h00000001, rsp);
    chk({30'h0, rsp}, 32'h2);
    axi_write(8'h04, 32'hffffffff, rsp);
    chk({30'h0, rsp}, 32'h0);
    axi_read(8'h04, rd, rsp);
    chk(rd, 32'h0);
  endtask

  // Five white reference scans fill the shading memory and hold the white peak
  task automatic t_calib;
    axi_write(8'h00, 32'h12, rsp);
    repeat (5) i_slb_video_model.send_line(8'ha0, 8'ha0);
    repeat (10) @(posedge MCLK);
    axi_read(8'h04, rd, rsp);
    chk(rd, 32'h0005a002);
  endtask

  // White line with brighter margins, black line, grey line with darker margins in line mode
  task automatic t_original;
    axi_write(8'h00, 32'h22, rsp);
    axi_read(8'h04, rd, rsp);
    chk(rd & 32'h0000ff06, 32'h6);
    i_slb_video_model.send_line(8'ha0, 8'hf0);
    chk(32'(n_valid), 32'h0);
    i_slb_video_model.send_line(8'h00, 8'h00);
    // Centre codes 5, margins codes 10 against the white peak
    i_slb_video_model.send_line(8'h6c, 8'h3c);
    repeat (20) @(posedge MCLK);
    chk(32'(n_valid), 32'd5184);
    chk(32'(n_first), 32'h2);
    chk(32'(n_black), 32'd2592);
    chk(32'(black_early), 32'h0);
    axi_read(8'h04, rd, rsp);
    chk({24'h0, rd[15:8]}, 32'ha0);
  endtask

  // Photo mode, darker 2, edge emphasis on: the grey line goes out on the third dither row
  // Margins (code 10) are dithered, three of four black; centre (code 5) sits next to a
  // black line above, so the filter takes over and leaves it white
  task automatic t_photo;
    axi_write(8'h00, 32'h0000000f, rsp);
    axi_read(8'h00, rd, rsp);
    chk(rd, 32'hf);
    i_slb_video_model.send_line(8'h00, 8'h00);
    repeat (20) @(posedge MCLK);
    chk(32'(n_valid), 32'd7776);
    chk(32'(n_first), 32'h3);
    chk(32'(n_black), 32'd4152);
  endtask

  initial
  begin
    repeat (3) @(posedge MCLK);
    ARST_N <= 1'b1;
    t_regs;
    t_calib;
    t_original;
    t_photo;
    finish_test;
  end

  initial
  begin
    repeat (100000) @(posedge MCLK);
    n_fail++;
    finish_test;
  end
endmodule

// ### tb/slb_video_model.sv
// Sensor front end model: sends whole scan lines of samples to the binarizer
// Assumes the binarizer syncs its video pins and latches video one clock after a strobe rise
`timescale 1ns/1ns
module slb_video_model
(
  input  wire logic       mclk,
  output logic      [7:0] video,
  output logic            strobe,
  output logic            line_start
);
  initial
  begin
    video = 8'h00;
    strobe = 1'b0;
    line_start = 1'b0;
  end

  // Samples outside the central 512 columns carry edge_v
  task automatic send_line(input logic [7:0] center_v, input logic [7:0] edge_v);
    int col;
    @(posedge mclk);
    line_start <= 1'b1;
    repeat (2) @(posedge mclk);
    line_start <= 1'b0;
    repeat (4) @(posedge mclk);
    for (col = 0; col < 2592; col++)
    begin
      @(posedge mclk);
      video <= (col >= 1040 && col < 1552) ? center_v : edge_v;
      strobe <= 1'b0;
      repeat (2) @(posedge mclk);
      strobe <= 1'b1;
      @(posedge mclk);
      // Past the hold time the line no longer shows the sample
      video <= ~video;
    end
    @(posedge mclk);
    strobe <= 1'b0;
  endtask
endmodule
